/* src/can_wake_frame_filter_regs.sv */
// configuration registers of the selective-wake frame filter and the compare against them
// assumes: register strobes and received frames are synchronous to clk, strobes last one cycle
// Contract
// R1 - identifier bit compared only where its mask bit is 1, ignored where 0
// R2 - low mask: id 12..5 at bits 15:8, id 4..0 at bits 6:2
// R3 - low mask bit 7, 1:0 and length bits 15:4 read zero, writes ignored
// R4 - restart keeps low mask contents; reserved bits still read zero
// R5 - high mask and payload 7/6 survive restart; power-on or soft reset clears them
// R6 - four-bit writable expected length code at bits 3:0
// R7 - codes 0..7 mean 0..7 bytes; 8..15 mean eight bytes; zero means cleared
// R8 - length matches only if all four code bits equal the configured code
// R9 - sending node states true data byte count, zero to eight, in its code
// R10 - restart keeps length code; power-on or soft reset clears it
// R11 - payload byte 7 at bits 15:8, byte 6 at bits 7:0, lsb lowest
// R12 - identifier bits 12..0 stored at same positions as their mask bits
// R13 - identifier matches only when every masked bit equals configured bit
`timescale 1ns/1ps
module can_wake_frame_filter_regs (
    input  wire logic                        clk,           // 100 MHz clock
    input  wire logic                        rst_n,         // power-on or soft reset
    input  wire logic                        restart,       // restart, keeps configuration
    input  wire logic                        reg_wr,        // register write strobe
    input  wire logic                        reg_rd,        // register read strobe
    input  wire logic [6:0]                  reg_addr,      // register address
    input  wire logic [15:0]                 reg_wdata,     // write data
    output logic      [15:0]                 reg_rdata,     // read data, one cycle after reg_rd
    output logic                             reg_ack,       // read or write taken, registered
    input  wire logic                        frame_valid,   // received wake-up frame strobe
    input  wire wake_filter_pkg::wake_frame_t frame,        // received frame fields
    output wake_filter_pkg::wake_result_t    result,        // compare result, registered
    output logic                             result_valid,  // result strobe
    output logic      [3:0]                  expected_bytes // decoded configured length
);

    logic [15:0] id_low_reg;
    logic [15:0] mask_high_reg;
    logic [15:0] mask_low_reg;
    logic [15:0] len_code_reg;
    logic [15:0] payload_reg;
    logic [15:0] rdata_next;
    logic [12:0] id_mask;
    logic [12:0] id_cfg;
    logic [3:0]  cfg_bytes;
    wake_filter_pkg::wake_result_t result_next;

    // identifier field layout shared by the mask and identifier registers
    function automatic logic [12:0] id_field(input logic [15:0] r);
        id_field = {r[wake_filter_pkg::ID_UPPER_MSB:wake_filter_pkg::ID_UPPER_LSB],
                    r[wake_filter_pkg::ID_LOWER_MSB:wake_filter_pkg::ID_LOWER_LSB]}; // [R2] [R12]
    endfunction

    function automatic logic [3:0] code_to_bytes(input logic [3:0] code);
        if (code > wake_filter_pkg::LEN_CODE_MAX_EXACT) begin
            code_to_bytes = wake_filter_pkg::LEN_BYTES_FULL; // [R7]
        end else begin
            code_to_bytes = code; // [R7]
        end
    endfunction

    function automatic logic wr_hit(input logic [6:0] a);
        wr_hit = reg_wr && (reg_addr == a);
    endfunction

    // restart is deliberately absent from every config flop: only rst_n clears them
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            id_low_reg <= wake_filter_pkg::RESET_VALUE;
        end else if (wr_hit(wake_filter_pkg::ADDR_WAKE_ID_LOW)) begin
            id_low_reg <= reg_wdata & wake_filter_pkg::WMASK_ID_LOW; // [R12]
        end
    end

    // the identifier shares the mask layout, so one field function serves both
    id_write_map_a: assert property (@(posedge clk) disable iff (!rst_n) // [R12]
        reg_wr && (reg_addr == wake_filter_pkg::ADDR_WAKE_ID_LOW)
        |=> (id_cfg == {$past(reg_wdata[15:8]), $past(reg_wdata[6:2])}) &&
            (id_low_reg[7] == 1'b0))
        else $error("identifier write lands in wrong bits");

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mask_high_reg <= wake_filter_pkg::RESET_VALUE; // [R5]
        end else if (wr_hit(wake_filter_pkg::ADDR_WAKE_ID_MASK_HIGH)) begin
            mask_high_reg <= reg_wdata & wake_filter_pkg::WMASK_FULL;
        end
    end

    // every bit of the high mask is writable storage
    mask_high_write_a: assert property (@(posedge clk) disable iff (!rst_n) // [R5]
        reg_wr && (reg_addr == wake_filter_pkg::ADDR_WAKE_ID_MASK_HIGH)
        |=> (mask_high_reg == $past(reg_wdata)))
        else $error("high mask write not stored");

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mask_low_reg <= wake_filter_pkg::RESET_VALUE; // [R4]
        end else if (wr_hit(wake_filter_pkg::ADDR_WAKE_ID_MASK_LOW)) begin
            mask_low_reg <= reg_wdata & wake_filter_pkg::WMASK_ID_MASK_LOW; // [R2] [R3]
        end
    end

    mask_reserved_zero_a: assert property (@(posedge clk) disable iff (!rst_n) // [R3]
        (mask_low_reg[7] == 1'b0) && (mask_low_reg[1:0] == 2'b00))
        else $error("reserved low mask bits not zero");

    mask_write_map_a: assert property (@(posedge clk) disable iff (!rst_n) // [R2]
        reg_wr && (reg_addr == wake_filter_pkg::ADDR_WAKE_ID_MASK_LOW)
        |=> (id_mask == {$past(reg_wdata[15:8]), $past(reg_wdata[6:2])}))
        else $error("low mask write lands in wrong bits");

    mask_ends_a: assert property (@(posedge clk) disable iff (!rst_n) // [R2]
        (id_mask[12] == mask_low_reg[15]) && (id_mask[0] == mask_low_reg[2]))
        else $error("mask field ends misplaced");

    // restart never reaches this flop, so only a write or rst_n may move it
    restart_keep_mask_a: assert property (@(posedge clk) disable iff (!rst_n) // [R4]
        restart && !reg_wr |=> $stable(mask_low_reg))
        else $error("restart disturbed low mask");

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            len_code_reg <= wake_filter_pkg::RESET_VALUE; // [R10]
        end else if (wr_hit(wake_filter_pkg::ADDR_WAKE_FRAME_LEN_CODE)) begin
            len_code_reg <= reg_wdata & wake_filter_pkg::WMASK_LEN_CODE; // [R6] [R3]
        end
    end

    len_reserved_zero_a: assert property (@(posedge clk) disable iff (!rst_n) // [R3]
        len_code_reg[15:4] == 12'h000)
        else $error("length code upper bits stored");

    restart_keep_len_a: assert property (@(posedge clk) disable iff (!rst_n) // [R10]
        restart && !reg_wr |=> $stable(len_code_reg))
        else $error("restart disturbed length code");

    // no disable here: the flops clear asynchronously, so the edge after
    // reset is seen low must already show the cleared value
    por_clear_len_a: assert property (@(posedge clk) // [R10]
        !rst_n |=> (len_code_reg == wake_filter_pkg::RESET_VALUE))
        else $error("length code not cleared by reset");

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            payload_reg <= wake_filter_pkg::RESET_VALUE; // [R5]
        end else if (wr_hit(wake_filter_pkg::ADDR_WAKE_PAYLOAD_7_6)) begin
            payload_reg <= reg_wdata & wake_filter_pkg::WMASK_FULL; // [R11]
        end
    end

    payload_write_map_a: assert property (@(posedge clk) disable iff (!rst_n) // [R11]
        reg_wr && (reg_addr == wake_filter_pkg::ADDR_WAKE_PAYLOAD_7_6)
        |=> (payload_reg == $past(reg_wdata)))
        else $error("payload write lands in wrong bits");

    restart_keep_cfg_a: assert property (@(posedge clk) disable iff (!rst_n) // [R5]
        restart && !reg_wr |=> $stable(mask_high_reg) && $stable(payload_reg))
        else $error("restart disturbed high mask or payload");

    por_clear_cfg_a: assert property (@(posedge clk) // [R5]
        !rst_n |=> (mask_high_reg == wake_filter_pkg::RESET_VALUE) &&
                   (payload_reg == wake_filter_pkg::RESET_VALUE))
        else $error("high mask or payload not cleared by reset");

    // unmapped addresses read as zero
    always_comb begin
        case (reg_addr)
            wake_filter_pkg::ADDR_WAKE_ID_LOW:         rdata_next = id_low_reg;
            wake_filter_pkg::ADDR_WAKE_ID_MASK_HIGH:   rdata_next = mask_high_reg;
            wake_filter_pkg::ADDR_WAKE_ID_MASK_LOW:    rdata_next = mask_low_reg;
            wake_filter_pkg::ADDR_WAKE_FRAME_LEN_CODE: rdata_next = len_code_reg;
            wake_filter_pkg::ADDR_WAKE_PAYLOAD_7_6:    rdata_next = payload_reg;
            default:                                   rdata_next = 16'h0000;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 16'h0000;
            reg_ack   <= 1'b0;
        end else begin
            reg_ack <= reg_wr | reg_rd;
            if (reg_rd) begin
                reg_rdata <= rdata_next;
            end
        end
    end

    len_upper_read_a: assert property (@(posedge clk) disable iff (!rst_n) // [R3]
        reg_rd && (reg_addr == wake_filter_pkg::ADDR_WAKE_FRAME_LEN_CODE)
        |=> (reg_rdata[15:4] == 12'h000))
        else $error("length code upper bits read nonzero");

    mask_read_reserved_a: assert property (@(posedge clk) disable iff (!rst_n) // [R3]
        reg_rd && (reg_addr == wake_filter_pkg::ADDR_WAKE_ID_MASK_LOW)
        |=> (reg_rdata[7] == 1'b0) && (reg_rdata[1:0] == 2'b00))
        else $error("low mask reserved bits read nonzero");

    // a read right behind the write must already see the new code
    len_write_a: assert property (@(posedge clk) disable iff (!rst_n) // [R6]
        reg_wr && (reg_addr == wake_filter_pkg::ADDR_WAKE_FRAME_LEN_CODE)
        ##1 reg_rd && (reg_addr == wake_filter_pkg::ADDR_WAKE_FRAME_LEN_CODE) && !reg_wr
        |=> (reg_rdata == {12'h000, $past(reg_wdata[3:0], 2)}))
        else $error("length code write not read back");

    payload_read_a: assert property (@(posedge clk) disable iff (!rst_n) // [R11]
        reg_rd && (reg_addr == wake_filter_pkg::ADDR_WAKE_PAYLOAD_7_6)
        |=> (reg_rdata == $past(payload_reg)))
        else $error("payload register read wrong");

    assign id_mask   = id_field(mask_low_reg);
    assign id_cfg    = id_field(id_low_reg);
    assign cfg_bytes = code_to_bytes(len_code_reg[3:0]);

    // only the lower 13 identifier bits are compared here; the high identifier
    // register lives elsewhere, so the high mask is storage only in this block
    always_comb begin
        result_next.id_match  = (((frame.id[12:0] ^ id_cfg) & id_mask) == 13'h0000); // [R1] [R13]
        result_next.len_match = (frame.dlc == len_code_reg[3:0]); // [R8]
        result_next.payload_match =
            ((cfg_bytes < wake_filter_pkg::LEN_BYTES_FULL) ||
             (frame.byte_7 == payload_reg[15:8])) &&
            ((cfg_bytes < wake_filter_pkg::LEN_BYTES_FOR_BYTE_6) ||
             (frame.byte_6 == payload_reg[7:0])); // [R11]
    end

    // restart drops a pending result but never the configuration
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            result       <= '0;
            result_valid <= 1'b0;
        end else if (restart) begin
            result       <= '0;
            result_valid <= 1'b0;
        end else begin
            result_valid <= frame_valid;
            if (frame_valid) begin
                result <= result_next;
            end
        end
    end

    unmasked_ignored_a: assert property (@(posedge clk) disable iff (!rst_n || restart) // [R1]
        frame_valid && (mask_low_reg == 16'h0000) ##1 !restart |-> result.id_match)
        else $error("id mismatch with all bits unmasked");

    masked_bit_compared_a: assert property (@(posedge clk) disable iff (!rst_n) // [R1]
        frame_valid && !restart && id_mask[0] && (frame.id[0] != id_cfg[0])
        |=> !result.id_match)
        else $error("masked identifier bit not compared");

    id_equal_match_a: assert property (@(posedge clk) disable iff (!rst_n) // [R13]
        frame_valid && !restart && (frame.id[12:0] == id_cfg)
        |=> result.id_match)
        else $error("equal identifier not matched");

    id_compare_a: assert property (@(posedge clk) disable iff (!rst_n) // [R13]
        frame_valid && !restart
        |=> result.id_match ==
            ((($past(frame.id[12:0]) ^ $past(id_cfg)) & $past(id_mask)) == 13'h0000))
        else $error("id compare result wrong");

    len_exact_a: assert property (@(posedge clk) disable iff (!rst_n) // [R8]
        frame_valid && !restart
        |=> result.len_match == ($past(frame.dlc) == $past(len_code_reg[3:0])))
        else $error("length compare not bitwise");

    // two codes that both mean eight bytes must still fail the length check
    len_mismatch_a: assert property (@(posedge clk) disable iff (!rst_n) // [R8]
        frame_valid && !restart && (frame.dlc != len_code_reg[3:0])
        |=> !result.len_match)
        else $error("differing length codes matched");

    // payload bytes only count when the configured length reaches them
    payload_compare_a: assert property (@(posedge clk) disable iff (!rst_n) // [R11]
        frame_valid && !restart &&
        (cfg_bytes >= wake_filter_pkg::LEN_BYTES_FOR_BYTE_6) &&
        (frame.byte_6 != payload_reg[7:0])
        |=> !result.payload_match)
        else $error("payload byte 6 mismatch not flagged");

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            expected_bytes <= 4'h0;
        end else begin
            expected_bytes <= cfg_bytes; // [R7]
        end
    end

    decode_full_a: assert property (@(posedge clk) disable iff (!rst_n) // [R7]
        (len_code_reg[3] == 1'b1) |=> (expected_bytes == 4'h8) || $changed(len_code_reg))
        else $error("long code not decoded as eight bytes");

    decode_short_a: assert property (@(posedge clk) disable iff (!rst_n) // [R7]
        (len_code_reg[3] == 1'b0) |=> (expected_bytes == $past(len_code_reg[3:0])))
        else $error("short code not decoded as its byte count");

    cover_match_c: cover property (@(posedge clk) disable iff (!rst_n)
        result_valid && result.id_match && result.len_match && result.payload_match);
    cover_long_code_c: cover property (@(posedge clk) disable iff (!rst_n)
        frame_valid && (frame.dlc == 4'h8) && (len_code_reg[3:0] == 4'hF));
    cover_restart_c: cover property (@(posedge clk) disable iff (!rst_n)
        restart && (mask_low_reg != 16'h0000));
    cover_short_len_c: cover property (@(posedge clk) disable iff (!rst_n)
        result_valid && (expected_bytes == 4'h6) && result.payload_match);
    cover_restart_frame_c: cover property (@(posedge clk) disable iff (!rst_n)
        frame_valid && restart);

endmodule

/* src/wake_filter_pkg.sv */
// constants and carriers for the selective-wake frame filter register bank
// assumes a decoded register port: 7-bit address, 16-bit data, one-cycle strobes
package wake_filter_pkg;

    localparam logic [6:0]  ADDR_WAKE_ID_LOW         = 7'h31; // identifier bits 12..0
    localparam logic [6:0]  ADDR_WAKE_ID_MASK_HIGH   = 7'h34;
    localparam logic [6:0]  ADDR_WAKE_ID_MASK_LOW    = 7'h35;
    localparam logic [6:0]  ADDR_WAKE_FRAME_LEN_CODE = 7'h36;
    localparam logic [6:0]  ADDR_WAKE_PAYLOAD_7_6    = 7'h37;

    localparam logic [15:0] RESET_VALUE              = 16'h0000;
    localparam logic [15:0] WMASK_ID_LOW             = 16'hFF7F; // bit 7 reserved
    localparam logic [15:0] WMASK_ID_MASK_LOW        = 16'hFF7C; // bits 7, 1:0 reserved
    localparam logic [15:0] WMASK_FULL               = 16'hFFFF;
    localparam logic [15:0] WMASK_LEN_CODE           = 16'h000F;

    localparam int          ID_UPPER_MSB             = 15;
    localparam int          ID_UPPER_LSB             = 8;
    localparam int          ID_LOWER_MSB             = 6;
    localparam int          ID_LOWER_LSB             = 2;
    localparam logic [3:0]  LEN_CODE_MAX_EXACT       = 4'h7;
    localparam logic [3:0]  LEN_BYTES_FULL           = 4'h8;
    localparam logic [3:0]  LEN_BYTES_FOR_BYTE_6     = 4'h7;

    typedef struct packed {
        logic [28:0] id;     // received identifier
        logic [3:0]  dlc;    // received length code
        logic [7:0]  byte_7; // received payload byte 7
        logic [7:0]  byte_6; // received payload byte 6
    } wake_frame_t;

    typedef struct packed {
        logic id_match;
        logic len_match;
        logic payload_match;
    } wake_result_t;

endpackage

/* test/frame_sender.sv */
// remote node model: sends received wake-up frames into the filter
// assumes the bench calls send at a falling clk edge and checks the result on return
`timescale 1ns/1ps
module frame_sender (
    input  wire logic                          clk,         // filter clock
    output logic                               frame_valid, // frame strobe
    output wake_filter_pkg::wake_frame_t       frame        // frame fields
);
    initial begin
        frame_valid = 1'b0;
        frame       = '0;
    end
    // a node never states more than eight data bytes
    task automatic send(input logic [28:0] id, input logic [3:0] dlc,
                        input logic [7:0] b7, input logic [7:0] b6);
        @(negedge clk);
        frame_valid = 1'b1;
        frame       = {id, (dlc > 4'h8) ? 4'h8 : dlc, b7, b6};
        @(negedge clk);
        frame_valid = 1'b0;
        // fields are stale once the strobe drops: show garbage, not the old frame
        frame       = ~frame;
    endtask
endmodule

/* test/testbench.sv */
// self-checking bench for the selective-wake filter register bank
// assumes the frame_sender model and the one-cycle strobe port of the filter
`timescale 1ns/1ps
module testbench;
    logic                          clk, rst_n, restart, reg_wr, reg_rd, reg_ack;
    logic                          frame_valid, result_valid;
    logic [6:0]                    reg_addr;
    logic [15:0]                   reg_wdata, reg_rdata;
    logic [3:0]                    expected_bytes;
    wake_filter_pkg::wake_frame_t  frame;
    wake_filter_pkg::wake_result_t result;
    int                            failures = 0;
    int                            checked = 0;

    can_wake_frame_filter_regs dut (.clk(clk), .rst_n(rst_n), .restart(restart),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_ack(reg_ack), .frame_valid(frame_valid),
        .frame(frame), .result(result), .result_valid(result_valid),
        .expected_bytes(expected_bytes));
    frame_sender node (.clk(clk), .frame_valid(frame_valid), .frame(frame));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        @(negedge clk);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(negedge clk);
        reg_wr    = 1'b0;
        chk({15'h0, reg_ack}, 16'h0001);
    endtask
    // reads and compares in one go
    task automatic rdc(input logic [6:0] a, input logic [15:0] exp);
        @(negedge clk);
        reg_addr = a;
        reg_rd   = 1'b1;
        @(negedge clk);
        reg_rd   = 1'b0;
        chk({15'h0, reg_ack}, 16'h0001);
        chk(reg_rdata, exp);
    endtask
    task automatic por();
        rst_n = 1'b0;
        repeat (3) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
    endtask
    task automatic frame_chk(input logic [28:0] id, input logic [3:0] dlc,
                             input logic [7:0] b6, input logic [2:0] e);
        node.send(id, dlc, 8'hA5, b6);
        chk({15'h0, result_valid}, 16'h0001);
        chk({13'h0, result}, {13'h0, e});
    endtask

    task automatic t_reset();
        rdc(wake_filter_pkg::ADDR_WAKE_ID_MASK_HIGH, 16'h0000);
        rdc(wake_filter_pkg::ADDR_WAKE_ID_MASK_LOW, 16'h0000);
        rdc(wake_filter_pkg::ADDR_WAKE_FRAME_LEN_CODE, 16'h0000);
        rdc(wake_filter_pkg::ADDR_WAKE_PAYLOAD_7_6, 16'h0000);
    endtask
    task automatic t_fields();
        wr(7'h35, 16'hFFFF);
        rdc(7'h35, 16'hFF7C);
        wr(7'h36, 16'hFFFF);
        rdc(7'h36, 16'h000F);
        wr(7'h37, 16'hA55A);
        rdc(7'h37, 16'hA55A);
        wr(7'h34, 16'hFFFF);
        rdc(7'h34, 16'hFFFF);
        wr(7'h31, 16'hFFFF);
        rdc(7'h31, 16'hFF7F);
        wr(7'h7F, 16'hFFFF);
        rdc(7'h7F, 16'h0000);
    endtask
    task automatic t_restart();
        @(negedge clk);
        restart = 1'b1;
        @(negedge clk);
        restart = 1'b0;
        rdc(7'h35, 16'hFF7C);
        rdc(7'h36, 16'h000F);
        rdc(7'h37, 16'hA55A);
        rdc(7'h34, 16'hFFFF);
        por();
        rdc(7'h34, 16'h0000);
        rdc(7'h37, 16'h0000);
        rdc(7'h36, 16'h0000);
    endtask
    task automatic t_len_decode();
        for (int c = 0; c < 16; c++) begin
            wr(7'h36, 16'(c));
            @(negedge clk);
            chk({12'h0, expected_bytes}, (c > 7) ? 16'h0008 : 16'(c));
        end
    endtask
    task automatic t_match();
        wr(7'h31, 16'hAB1C); // id 0x1567 spread over the mask positions
        wr(7'h35, 16'hFF7C);
        wr(7'h36, 16'h0008);
        wr(7'h37, 16'hA55A);
        frame_chk(29'h1567, 4'h8, 8'h5A, 3'b111);
        frame_chk(29'h1566, 4'h8, 8'h5B, 3'b010);
        wr(7'h35, 16'hFF78);
        frame_chk(29'h1566, 4'h8, 8'h5A, 3'b111);
        wr(7'h36, 16'h000F);
        frame_chk(29'h1567, 4'h8, 8'h5A, 3'b101);
        @(negedge clk);
        restart = 1'b1;
        node.send(29'h1567, 4'h8, 8'hA5, 8'h5A);
        restart = 1'b0;
        chk({15'h0, result_valid}, 16'h0000);
        wr(7'h35, 16'h0000);
        frame_chk(29'h0000, 4'h8, 8'h5A, 3'b101);
        wr(7'h36, 16'h0007);
        frame_chk(29'h1567, 4'h7, 8'h00, 3'b110);
        wr(7'h36, 16'h0006);
        frame_chk(29'h1567, 4'h6, 8'h00, 3'b111);
    endtask
    // write and read back to back, no idle cycle between
    task automatic t_wr_then_rd();
        @(negedge clk);
        reg_addr  = wake_filter_pkg::ADDR_WAKE_FRAME_LEN_CODE;
        reg_wdata = 16'h00A5;
        reg_wr    = 1'b1;
        @(negedge clk);
        reg_wr    = 1'b0;
        reg_rd    = 1'b1;
        chk({15'h0, reg_ack}, 16'h0001);
        @(negedge clk);
        reg_rd    = 1'b0;
        chk({15'h0, reg_ack}, 16'h0001);
        chk(reg_rdata, 16'h0005);
    endtask

    task automatic close_out();
        $display("comparisons %0d, failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        #100us;
        failures++;
        close_out();
    end
    initial begin
        rst_n     = 1'b0;
        restart   = 1'b0;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = 7'h00;
        reg_wdata = 16'h0000;
        por();
        t_reset();
        t_fields();
        t_restart();
        t_len_decode();
        t_wr_then_rd();
        t_match();
        close_out();
    end
endmodule
